// [rtl/epag_cfg.svh]
// Timing constants and fixed figures for the encoder access gate
`ifndef EPAG_CFG_SVH
`define EPAG_CFG_SVH

// ----------------------------------------
// Clock and timebase
// ----------------------------------------
`define EPAG_CLK_HZ          20000000
`define EPAG_TICK_HZ         1000
`define EPAG_TICK_DIV        (`EPAG_CLK_HZ / `EPAG_TICK_HZ)

// ----------------------------------------
// Times in milliseconds, counts in ticks
// ----------------------------------------
`define EPAG_CREATE_MS       15000
`define EPAG_GAP_MS          2000
`define EPAG_IDLE_LONG_MS    900000
`define EPAG_IDLE_SHORT_MS   30000
`define EPAG_BLINK_MS        250
`define EPAG_DEBOUNCE_MS     10
`define EPAG_MS_TO_TICKS(ms) (((ms) * `EPAG_TICK_HZ) / 1000)

// ----------------------------------------
// Code length
// ----------------------------------------
`define EPAG_CODE_LEN        4

`endif

// [rtl/epag_pkg.sv]
// Types shared by the encoder access gate
package epag_pkg;

  // ----------------------------------------
  // Main state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    EPAG_IDLE   = 2'b00,
    EPAG_CREATE = 2'b01,
    EPAG_ENTRY  = 2'b10,
    EPAG_OPEN   = 2'b11
  } epag_state_t;

  // ----------------------------------------
  // Status carried out of the block
  // ----------------------------------------
  typedef struct packed {
    logic code_stored;
    logic unlocked;
    logic creating;
  } epag_status_t;

endpackage

// [rtl/epag_gate.sv]
// Code-protected access gate of a push-button remote encoder
`timescale 1ns/1ps
`default_nettype none
`include "epag_cfg.svh"

module epag_gate #(
  parameter int NUM_LINES      = 8,
  parameter int TICK_DIV       = `EPAG_TICK_DIV,
  parameter int CREATE_TICKS   = `EPAG_MS_TO_TICKS(`EPAG_CREATE_MS),
  parameter int GAP_TICKS      = `EPAG_MS_TO_TICKS(`EPAG_GAP_MS),
  parameter int IDLE_LONG_TICKS  = `EPAG_MS_TO_TICKS(`EPAG_IDLE_LONG_MS),
  parameter int IDLE_SHORT_TICKS = `EPAG_MS_TO_TICKS(`EPAG_IDLE_SHORT_MS),
  parameter int BLINK_TICKS    = `EPAG_MS_TO_TICKS(`EPAG_BLINK_MS),
  parameter int DEB_TICKS      = `EPAG_MS_TO_TICKS(`EPAG_DEBOUNCE_MS)
) (
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 sys_rst_in,
  // User buttons, period select and key-learned input
  input  wire logic [NUM_LINES-1:0] data_lines_in,
  input  wire logic                 create_in,
  input  wire logic                 send_in,
  input  wire logic                 period_sel_in,
  input  wire logic                 key_learned_in,
  // Indications and gate
  output logic                      activity_indicator_out,
  output logic                      tx_enable_out,
  output epag_pkg::epag_status_t    status_out
);

  localparam int TW  = 20;
  localparam int IW  = $clog2(NUM_LINES);
  localparam int NIN = NUM_LINES + 1;

  // ----------------------------------------
  // Helper: index of highest set line
  // ----------------------------------------
  function automatic logic [IW-1:0] line_index(input logic [NUM_LINES-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (v[i])
      begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Slow timebase: one tick per millisecond
  // ----------------------------------------
  logic [TW-1:0] div_q, div_d;
  logic          tick;

  always_comb
  begin
    tick  = (div_q == TW'(TICK_DIV - 1));
    div_d = tick ? '0 : div_q + TW'(1);
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      div_q <= '0;
    else
      div_q <= div_d;
  end

  // ----------------------------------------
  // Synchronise and debounce the data lines and the setup input
  // ----------------------------------------
  // Bit NUM_LINES is the setup input; the rest are data lines
  logic [NIN-1:0] raw;
  logic [NIN-1:0] fall;
  assign raw = {create_in, data_lines_in};

  genvar g;
  generate
    for (g = 0; g < NIN; g++)
    begin : g_deb
      logic       s1_q, s2_q, st_q, st_d, fl_d, fl_q;
      logic [7:0] cnt_q, cnt_d;

      // Debounce: level must hold DEB_TICKS before accepted
      always_comb
      begin
        st_d  = st_q;
        cnt_d = cnt_q;
        fl_d  = 1'b0;
        if (s2_q == st_q)
          cnt_d = '0;
        else if (tick)
        begin
          if (cnt_q == 8'(DEB_TICKS - 1))
          begin
            st_d  = s2_q;
            cnt_d = '0;
            fl_d  = st_q;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
      end

      always_ff @(posedge sys_clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          st_q  <= 1'b0;
          cnt_q <= 8'h00;
          fl_q  <= 1'b0;
        end
        else
        begin
          s1_q  <= raw[g];
          s2_q  <= s1_q;
          st_q  <= st_d;
          cnt_q <= cnt_d;
          fl_q  <= fl_d;
        end
      end

      assign fall[g] = fl_q;
    end
  endgenerate

  // ----------------------------------------
  // Main gate state
  // ----------------------------------------
  epag_pkg::epag_state_t st_q, st_d;
  logic [IW-1:0] code_q   [`EPAG_CODE_LEN], code_d [`EPAG_CODE_LEN];
  logic [IW-1:0] ent_q    [`EPAG_CODE_LEN], ent_d  [`EPAG_CODE_LEN];
  logic          stored_q, stored_d;
  logic [2:0]    cnt_q, cnt_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [TW-1:0] blink_q, blink_d;
  logic          ind_q, ind_d;
  logic          tx_q, tx_d;
  logic          data_fall, setup_fall, match;
  logic [TW-1:0] idle_lim;

  always_comb
  begin
    data_fall  = |fall[NUM_LINES-1:0];
    setup_fall = fall[NUM_LINES];
    idle_lim   = period_sel_in ? TW'(IDLE_SHORT_TICKS) : TW'(IDLE_LONG_TICKS);
    match      = 1'b1;
    for (int i = 0; i < `EPAG_CODE_LEN; i++)
    begin
      if (ent_q[i] != code_q[i])
        match = 1'b0;
    end

    st_d     = st_q;
    code_d   = code_q;
    ent_d    = ent_q;
    stored_d = stored_q;
    cnt_d    = cnt_q;
    tmr_d    = (tick && tmr_q != '1) ? tmr_q + TW'(1) : tmr_q;
    blink_d  = blink_q;
    ind_d    = 1'b0;

    case (st_q)
      epag_pkg::EPAG_IDLE:
      begin
        // A locked gate refuses setup, else anyone could replace the code
        if (setup_fall && !stored_q)
        begin
          st_d  = epag_pkg::EPAG_CREATE;
          cnt_d = '0;
          tmr_d = '0;
        end
        else if (stored_q && data_fall)
        begin
          // Wait between entries; tmr resets per entry
          if (cnt_q != 3'd0 && tmr_q > TW'(GAP_TICKS))
            cnt_d = 3'd1;
          else
            cnt_d = cnt_q + 3'd1;
          ent_d[cnt_d[1:0] - 2'd1] = line_index(fall[NUM_LINES-1:0]);
          tmr_d = '0;
        end
        else if (stored_q && cnt_q == 3'(`EPAG_CODE_LEN))
        begin
          cnt_d = '0;
          if (match)
          begin
            st_d  = epag_pkg::EPAG_OPEN;
            tmr_d = '0;
          end
        end
        else if (stored_q && cnt_q != 3'd0 && tmr_q > TW'(GAP_TICKS))
          cnt_d = '0;
      end

      epag_pkg::EPAG_CREATE:
      begin
        if (tick)
          blink_d = blink_q + TW'(1);
        if (blink_q >= TW'(BLINK_TICKS))
          blink_d = '0;
        ind_d = 1'b1;
        if (setup_fall || tmr_q >= TW'(CREATE_TICKS))
        begin
          st_d  = epag_pkg::EPAG_IDLE;
          cnt_d = '0;
          ind_d = 1'b0;
        end
        else if (data_fall)
        begin
          code_d[cnt_q[1:0]] = line_index(fall[NUM_LINES-1:0]);
          cnt_d = cnt_q + 3'd1;
          if (cnt_q == 3'(`EPAG_CODE_LEN - 1))
          begin
            stored_d = 1'b1;
            st_d     = epag_pkg::EPAG_IDLE;
            cnt_d    = '0;
            ind_d    = 1'b0;
          end
        end
      end

      epag_pkg::EPAG_OPEN:
      begin
        if (send_in || data_fall)
          tmr_d = '0;
        else if (tmr_q > idle_lim)
          st_d = epag_pkg::EPAG_IDLE;
        if (setup_fall)
        begin
          st_d  = epag_pkg::EPAG_CREATE;
          cnt_d = '0;
          tmr_d = '0;
        end
      end

      default:
        st_d = epag_pkg::EPAG_IDLE;
    endcase

    // Toggling phase of the indicator while creating
    if (st_d == epag_pkg::EPAG_CREATE)
      ind_d = (blink_d < TW'(BLINK_TICKS / 2)) ? 1'b1 : 1'b0;
    else
      blink_d = '0;

    // Only a newly learned key erases the code
    if (key_learned_in)
    begin
      stored_d = 1'b0;
      cnt_d    = '0;
      if (st_d == epag_pkg::EPAG_OPEN)
        st_d = epag_pkg::EPAG_IDLE;
    end

    // Send is passed only when unlocked or no code exists
    tx_d = send_in && (!stored_d || st_d == epag_pkg::EPAG_OPEN)
           && st_d != epag_pkg::EPAG_CREATE;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q     <= epag_pkg::EPAG_IDLE;
      stored_q <= 1'b0;
      cnt_q    <= 3'd0;
      tmr_q    <= '0;
      blink_q  <= '0;
      ind_q    <= 1'b0;
      tx_q     <= 1'b0;
      for (int i = 0; i < `EPAG_CODE_LEN; i++)
      begin
        code_q[i] <= '0;
        ent_q[i]  <= '0;
      end
    end
    else
    begin
      st_q     <= st_d;
      stored_q <= stored_d;
      cnt_q    <= cnt_d;
      tmr_q    <= tmr_d;
      blink_q  <= blink_d;
      ind_q    <= ind_d;
      tx_q     <= tx_d;
      code_q   <= code_d;
      ent_q    <= ent_d;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  epag_pkg::epag_status_t stat_q;

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      stat_q <= '0;
    else
    begin
      stat_q.code_stored <= stored_d;
      stat_q.unlocked    <= (st_d == epag_pkg::EPAG_OPEN);
      stat_q.creating    <= (st_d == epag_pkg::EPAG_CREATE);
    end
  end

  assign activity_indicator_out = ind_q;
  assign tx_enable_out          = tx_q;
  assign status_out             = stat_q;

endmodule
`default_nettype wire

// [test/epag_gate_asserts.sv]
// Port checker for the encoder access gate
`timescale 1ns/1ps
`default_nettype none
module epag_gate_asserts #(
  parameter int NUM_LINES    = 8,
  parameter int TICK_DIV     = 4,
  parameter int CREATE_TICKS = 100,
  parameter int BLINK_TICKS  = 4
) (
  // Clock and reset
  input wire logic                   sys_clk_in,
  input wire logic                   sys_rst_in,
  // Inputs
  input wire logic [NUM_LINES-1:0]   data_lines_in,
  input wire logic                   create_in,
  input wire logic                   send_in,
  input wire logic                   period_sel_in,
  input wire logic                   key_learned_in,
  // Outputs
  input wire logic                   activity_indicator_out,
  input wire logic                   tx_enable_out,
  input wire epag_pkg::epag_status_t status_out
);
  // ----------
  // Properties
  // ----------
  // Two ticks of slack cover tick phase and sync stages
  localparam int CMAX = (CREATE_TICKS + 2) * TICK_DIV;
  localparam int BMAX = (BLINK_TICKS + 2) * TICK_DIV;
  wire logic stored = status_out.code_stored;
  wire logic opened = status_out.unlocked;
  wire logic making = status_out.creating;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_ind_on; $rose(making) |-> ##[1:BMAX] activity_indicator_out; endproperty
  a_ind_on: assert property (p_ind_on) else $error("indicator dark in creation");
  property p_make_end; $rose(making) |-> ##[1:CMAX] !making; endproperty
  a_make_end: assert property (p_make_end) else $error("creation overran");
  property p_ind_off; (!making) [*2] |-> !activity_indicator_out; endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator lit outside creation");
  property p_tx_lock; (stored && !opened) [*2] |-> !tx_enable_out; endproperty
  a_tx_lock: assert property (p_tx_lock) else $error("transmit while locked");
  property p_free_tx; (!stored && !making && send_in) [*3] |-> tx_enable_out; endproperty
  a_free_tx: assert property (p_free_tx) else $error("send ignored without code");
  property p_keep; (!key_learned_in) [*4] ##0 stored |=> stored; endproperty
  a_keep: assert property (p_keep) else $error("code lost");
  property p_open_code; opened |-> stored; endproperty
  a_open_code: assert property (p_open_code) else $error("open without code");
  property p_open_hold; opened && send_in && !key_learned_in |=> opened || making; endproperty
  a_open_hold: assert property (p_open_hold) else $error("closed while active");
  c_make: cover property ($fell(making) && stored);
  c_open: cover property ($rose(opened));
  c_clear: cover property ($fell(stored));
endmodule
`default_nettype wire

// [test/epag_user.sv]
// Push-button user driving data and setup lines
`timescale 1ns/1ps
`default_nettype none
module epag_user #(
  parameter int HOLD = 20
) (
  // Clock
  input  wire logic      sys_clk_in,
  // Buttons, pulled down when released
  output var logic [7:0] data_lines_out,
  output var logic       create_out
);
  // Released buttons sit at the pull-down level
  initial
  begin
    data_lines_out = 8'h00;
    create_out = 1'b0;
  end
  // One press, held past debounce; index below zero is setup
  task automatic press(input int idx);
    @(negedge sys_clk_in);
    if (idx < 0)
      create_out = 1'b1;
    else
      data_lines_out[idx] = 1'b1;
    repeat (HOLD) @(negedge sys_clk_in);
    data_lines_out = 8'h00;
    create_out = 1'b0;
    repeat (HOLD) @(negedge sys_clk_in);
  endtask
endmodule
`default_nettype wire

// [test/tb_epag_gate.sv]
// Self-checking bench for the encoder access gate
`timescale 1ns/1ps
`default_nettype none
module tb_epag_gate;
  // -------
  // Signals
  // -------
  logic                   sys_clk_in;
  logic                   sys_rst_in;
  logic [7:0]             data_lines_in;
  logic                   create_in;
  logic                   send_in;
  logic                   period_sel_in;
  logic                   key_learned_in;
  logic                   ind;
  logic                   tx;
  epag_pkg::epag_status_t st;
  int                     err_total = 0;
  int                     tests_run = 0;
  int                     cyc = 0;
  epag_user u_user (.sys_clk_in(sys_clk_in), .data_lines_out(data_lines_in), .create_out(create_in));
  // Short counts: a tick is four clocks
  epag_gate #(.TICK_DIV(4), .CREATE_TICKS(100), .GAP_TICKS(20), .IDLE_LONG_TICKS(200),
    .IDLE_SHORT_TICKS(50), .BLINK_TICKS(4), .DEB_TICKS(2)) uut (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .data_lines_in(data_lines_in), .create_in(create_in), .send_in(send_in),
    .period_sel_in(period_sel_in), .key_learned_in(key_learned_in), .activity_indicator_out(ind),
    .tx_enable_out(tx), .status_out(st));
  // Clock and hang guard
  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  // -------
  // Helpers
  // -------
  task automatic chk_st(string n, logic [2:0] e);
    tests_run++;
    if (st !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, st);
      err_total++;
    end
  endtask
  task automatic chk_b(string n, logic e, logic g);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %s exp %b got %b", n, e, g);
      err_total++;
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // The code used throughout: lines 3, 1, 7, 0
  task automatic code();
    u_user.press(3);
    u_user.press(1);
    u_user.press(7);
    u_user.press(0);
    wt(8);
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_free();
    send_in = 1'b1;
    u_user.press(2);
    chk_st("st", 3'h0);
    chk_b("tx", 1'b1, tx);
    send_in = 1'b0;
  endtask
  task automatic t_tmo();
    int seen;
    seen = 0;
    u_user.press(-1);
    chk_st("st", 3'h1);
    repeat (40)
    begin
      @(negedge sys_clk_in);
      if (ind === 1'b1)
        seen++;
    end
    chk_b("blink", 1'b1, seen > 0 && seen < 40);
    wt(260);
    chk_st("st", 3'h1);
    wt(120);
    chk_st("st", 3'h0);
  endtask
  task automatic t_cancel();
    u_user.press(-1);
    u_user.press(2);
    u_user.press(-1);
    chk_st("st", 3'h0);
    chk_b("ind", 1'b0, ind);
  endtask
  task automatic t_make();
    u_user.press(-1);
    code();
    chk_st("st", 3'h4);
    chk_b("ind", 1'b0, ind);
  endtask
  task automatic t_entry();
    send_in = 1'b1;
    u_user.press(-1);
    chk_st("st", 3'h4);
    u_user.press(3);
    u_user.press(1);
    u_user.press(7);
    chk_st("st", 3'h4);
    chk_b("tx", 1'b0, tx);
    u_user.press(5);
    chk_st("st", 3'h4);
    u_user.press(4);
    u_user.press(6);
    wt(100);
    u_user.press(7);
    u_user.press(0);
    chk_st("st", 3'h4);
    wt(100);
    code();
    chk_st("st", 3'h6);
    chk_b("tx", 1'b1, tx);
  endtask
  task automatic t_idle();
    send_in = 1'b0;
    period_sel_in = 1'b1;
    wt(150);
    chk_st("st", 3'h6);
    wt(130);
    chk_st("st", 3'h4);
    period_sel_in = 1'b0;
    code();
    wt(700);
    chk_st("st", 3'h6);
    wt(200);
    chk_st("st", 3'h4);
  endtask
  task automatic t_key();
    key_learned_in = 1'b1;
    wt(4);
    key_learned_in = 1'b0;
    wt(8);
    chk_st("st", 3'h0);
    send_in = 1'b1;
    wt(4);
    chk_b("tx", 1'b1, tx);
    send_in = 1'b0;
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    send_in = 1'b0;
    period_sel_in = 1'b0;
    key_learned_in = 1'b0;
    wt(20);
    sys_rst_in = 1'b0;
    t_free();
    t_tmo();
    t_cancel();
    t_make();
    t_entry();
    t_idle();
    t_key();
    report_and_stop();
  end
endmodule
bind epag_gate epag_gate_asserts #(.NUM_LINES(NUM_LINES), .TICK_DIV(TICK_DIV), .CREATE_TICKS(CREATE_TICKS),
  .BLINK_TICKS(BLINK_TICKS)) u_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .data_lines_in(data_lines_in), .create_in(create_in), .send_in(send_in), .period_sel_in(period_sel_in),
  .key_learned_in(key_learned_in), .activity_indicator_out(activity_indicator_out),
  .tx_enable_out(tx_enable_out), .status_out(status_out));
`default_nettype wire
